/* src/mpurc_device.sv */
// region start and region attribute registers with the region descriptor table
// assumes the core end issues at most one write and one read per cycle on the link
//
// How it works
// RQ1 - registers exist only with protection hardware present
// RQ2 - start field is address bits 31:8
// RQ3 - low start bits below minimum size read zero
// RQ4 - high start bits beyond address space read zero
// RQ5 - select bit one means data region
// RQ6 - index picks one of 32; unused bits zero
// RQ7 - index and select choose accessed descriptor
// RQ8 - attribute holds rest; start holds base
// RQ9 - build option picks size or bound field
// RQ10 - memory type: peripheral, normal, device, reserved
// RQ11 - access rights stored and returned unchanged
// RQ12 - fetch flag loads descriptor into both registers
// RQ13 - store flag writes both registers into descriptor
// RQ14 - size field as wide as start field
// RQ15 - unused size bits read zero
// RQ16 - size code is ones shifted by log2
// RQ17 - bound field one bit wider than size
// RQ18 - bound is end plus one, bit 31 extra
// RQ19 - data permission codes zero through six
// RQ20 - fetch and store flags read zero
// RQ21 - software never sets both flags together
// RQ22 - store bit0, fetch bit1, rights 4:2, type 6:5
// RQ23 - both registers clear on reset
//
// Our own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "mpurc_defs.svh"
module mpurc_device #(
	parameter bit MPU_PRESENT = 1'b1,
	parameter int REGION_BITS = 5,
	parameter int MIN_REGION_LOG2 = 8,
	parameter int ADDR_BITS = 32,
	parameter bit USE_LIMIT = 1'b0
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// control-register link
	mpurc_ctl_if.device ctl,
	// descriptor lookup request
	input wire logic lookup_data,
	input wire logic [REGION_BITS-1:0] lookup_index,
	// descriptor lookup answer
	output logic [`MPURC_BASE_W-1:0] lookup_base,
	output logic [`MPURC_BOUND_W-1:0] lookup_limit,
	output logic lookup_cacheable,
	output logic lookup_bufferable,
	output logic lookup_sup_read,
	output logic lookup_sup_write,
	output logic lookup_user_read,
	output logic lookup_user_write,
	output logic lookup_sup_exec,
	output logic lookup_user_exec
);
	localparam int SLOT_W = REGION_BITS + 1;
	localparam int NSLOT = 1 << SLOT_W;
	localparam int KEEP_LO = MIN_REGION_LOG2 - `MPURC_BASE_LSB;
	localparam int BASE_HI = ADDR_BITS - `MPURC_BASE_LSB - 1;
	localparam int BOUND_HI = USE_LIMIT ? BASE_HI + 1 : BASE_HI;
	localparam logic [`MPURC_BASE_W-1:0] MASK_FILL = ~`MPURC_BASE_W'((1 << (BASE_HI + 1)) - 1);

	// programming registers
	logic [`MPURC_BASE_W-1:0] base_reg;
	logic [REGION_BITS-1:0] index_reg;
	logic data_sel_reg;
	logic [`MPURC_BOUND_W-1:0] bound_reg;
	mpurc_pkg::mpurc_mem_type mt_reg;
	mpurc_pkg::mpurc_access_rights_type access_rights_reg;

	// descriptor table, one slot per region and space
	logic [`MPURC_BASE_W-1:0] base_mem [NSLOT];
	logic [`MPURC_BOUND_W-1:0] bound_mem [NSLOT];
	mpurc_pkg::mpurc_mem_type mt_mem [NSLOT];
	mpurc_pkg::mpurc_access_rights_type access_rights_mem [NSLOT];

	logic start_wr;
	logic attr_wr;
	logic fetch_op;
	logic store_op;
	logic [SLOT_W-1:0] slot;
	logic [SLOT_W-1:0] lookup_slot;
	logic [`MPURC_BASE_W-1:0] wr_base;
	logic [`MPURC_BOUND_W-1:0] wr_bound_raw;
	logic [`MPURC_BOUND_W-1:0] wr_bound;
	mpurc_pkg::mpurc_mem_type wr_mt;
	mpurc_pkg::mpurc_access_rights_type wr_access_rights;
	logic [`MPURC_INDEX_W-1:0] index_wide;
	logic [31:0] start_view;
	logic [31:0] attr_view;

	// absent hardware ignores every write and reads as zero
	assign start_wr = MPU_PRESENT && ctl.wr && !ctl.wsel; // RQ1
	assign attr_wr = MPU_PRESENT && ctl.wr && ctl.wsel; // RQ1
	// both flags together is undefined; fetch is given the edge
	assign fetch_op = attr_wr && ctl.wdata[`MPURC_FETCH_BIT]; // RQ12 RQ22
	assign store_op = attr_wr && ctl.wdata[`MPURC_STORE_BIT] && !fetch_op; // RQ13 RQ22 RQ21
	assign slot = {data_sel_reg, index_reg}; // RQ7 RQ5
	assign lookup_slot = {lookup_data, lookup_index};

	mpurc_field_mask #(
		.WIDTH(`MPURC_BASE_W),
		.KEEP_LO(KEEP_LO),
		.KEEP_HI(BASE_HI)
	) base_clean (
		.raw_bits(ctl.wdata[31:`MPURC_BASE_LSB]), // RQ2
		.clean_bits(wr_base) // RQ3 RQ4
	);

	// size code sits in 30:7 so it matches the start field width; bound takes bit 31 too
	always_comb begin
		if (USE_LIMIT) begin
			wr_bound_raw = ctl.wdata[31:`MPURC_BOUND_LSB]; // RQ17 RQ18 RQ9
		end else begin
			wr_bound_raw = {1'b0, ctl.wdata[30:`MPURC_BOUND_LSB]}; // RQ14 RQ9
		end
	end

	mpurc_field_mask #(
		.WIDTH(`MPURC_BOUND_W),
		.KEEP_LO(KEEP_LO),
		.KEEP_HI(BOUND_HI)
	) bound_clean (
		.raw_bits(wr_bound_raw),
		.clean_bits(wr_bound) // RQ15
	);

	// instruction regions have no memory type
	always_comb begin
		wr_access_rights = ctl.wdata[`MPURC_ACCESS_RIGHTS_LSB +: `MPURC_ACCESS_RIGHTS_W]; // RQ11
		if (data_sel_reg) begin
			wr_mt = mpurc_pkg::mpurc_mem_type'(ctl.wdata[`MPURC_MT_LSB +: `MPURC_MT_W]); // RQ10
		end else begin
			wr_mt = mpurc_pkg::MPURC_MT_PERIPH;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			base_reg <= '0; // RQ23
			index_reg <= '0;
			data_sel_reg <= 1'b0;
		end else if (fetch_op) begin
			base_reg <= base_mem[slot]; // RQ12 RQ8
		end else if (start_wr) begin
			base_reg <= wr_base;
			index_reg <= ctl.wdata[`MPURC_INDEX_LSB +: REGION_BITS]; // RQ6
			data_sel_reg <= ctl.wdata[`MPURC_DSEL_BIT]; // RQ5
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bound_reg <= '0; // RQ23
			mt_reg <= mpurc_pkg::MPURC_MT_PERIPH;
			access_rights_reg <= '0;
		end else if (fetch_op) begin
			bound_reg <= bound_mem[slot]; // RQ12
			mt_reg <= mt_mem[slot];
			access_rights_reg <= access_rights_mem[slot];
		end else if (attr_wr) begin
			bound_reg <= wr_bound;
			mt_reg <= wr_mt;
			access_rights_reg <= wr_access_rights; // RQ11
		end
	end

	// store takes the values written in the same access, not the stale ones
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < NSLOT; i++) begin
				base_mem[i] <= '0;
				bound_mem[i] <= '0;
				mt_mem[i] <= mpurc_pkg::MPURC_MT_PERIPH;
				access_rights_mem[i] <= '0;
			end
		end else if (store_op) begin
			base_mem[slot] <= base_reg; // RQ13 RQ8
			bound_mem[slot] <= wr_bound;
			mt_mem[slot] <= wr_mt;
			access_rights_mem[slot] <= wr_access_rights;
		end
	end

	// read views; flags always return zero
	always_comb begin
		index_wide = '0;
		index_wide[REGION_BITS-1:0] = index_reg; // RQ6
		start_view = {base_reg, 2'b00, index_wide, data_sel_reg};
		attr_view = {bound_reg, mt_reg, access_rights_reg, 2'b00}; // RQ20 RQ22
		if (!MPU_PRESENT) begin
			start_view = '0; // RQ1
			attr_view = '0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctl.rdata <= '0;
			ctl.rvalid <= 1'b0;
		end else begin
			ctl.rvalid <= ctl.rd;
			if (ctl.rd) begin
				ctl.rdata <= ctl.rsel ? attr_view : start_view;
			end
		end
	end

	// lookup: size code turns into an end bound, so both variants answer alike
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lookup_base <= '0;
			lookup_limit <= '0;
		end else begin
			lookup_base <= base_mem[lookup_slot];
			if (USE_LIMIT) begin
				lookup_limit <= bound_mem[lookup_slot]; // RQ18
			end else begin
				// code bits above a narrow address space are stored clear but mean ones
				lookup_limit <= {1'b0, base_mem[lookup_slot]}
					+ {1'b0, ~(bound_mem[lookup_slot][`MPURC_BASE_W-1:0] | MASK_FILL)}
					+ `MPURC_BOUND_W'(1); // RQ16
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lookup_cacheable <= 1'b0;
			lookup_bufferable <= 1'b0;
		end else begin
			lookup_cacheable <= lookup_data && mt_mem[lookup_slot] == mpurc_pkg::MPURC_MT_NORMAL; // RQ10
			lookup_bufferable <= lookup_data && (mt_mem[lookup_slot] == mpurc_pkg::MPURC_MT_NORMAL
				|| mt_mem[lookup_slot] == mpurc_pkg::MPURC_MT_DEVICE); // RQ10
		end
	end

	// reserved permission codes grant nothing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lookup_sup_read <= 1'b0;
			lookup_sup_write <= 1'b0;
			lookup_user_read <= 1'b0;
			lookup_user_write <= 1'b0;
			lookup_sup_exec <= 1'b0;
			lookup_user_exec <= 1'b0;
		end else begin
			lookup_sup_read <= lookup_data && (access_rights_mem[lookup_slot] inside {`MPURC_ACCESS_RIGHTS_SUP_R, `MPURC_ACCESS_RIGHTS_ALL_R,
				`MPURC_ACCESS_RIGHTS_SUP_RW, `MPURC_ACCESS_RIGHTS_SUP_RW_USR_R, `MPURC_ACCESS_RIGHTS_ALL_RW}); // RQ19
			lookup_sup_write <= lookup_data && (access_rights_mem[lookup_slot] inside {`MPURC_ACCESS_RIGHTS_SUP_RW,
				`MPURC_ACCESS_RIGHTS_SUP_RW_USR_R, `MPURC_ACCESS_RIGHTS_ALL_RW}); // RQ19
			lookup_user_read <= lookup_data && (access_rights_mem[lookup_slot] inside {`MPURC_ACCESS_RIGHTS_ALL_R,
				`MPURC_ACCESS_RIGHTS_SUP_RW_USR_R, `MPURC_ACCESS_RIGHTS_ALL_RW}); // RQ19
			lookup_user_write <= lookup_data && access_rights_mem[lookup_slot] == `MPURC_ACCESS_RIGHTS_ALL_RW; // RQ19
			lookup_sup_exec <= !lookup_data && (access_rights_mem[lookup_slot] inside {`MPURC_ACCESS_RIGHTS_SUP_R,
				`MPURC_ACCESS_RIGHTS_ALL_R});
			lookup_user_exec <= !lookup_data && access_rights_mem[lookup_slot] == `MPURC_ACCESS_RIGHTS_ALL_R;
		end
	end
endmodule

/* src/mpurc_defs.svh */
// constants for the region configuration registers and their bus front end
// assumes it is included by bare name from every file that needs a figure
`ifndef MPURC_DEFS_SVH
`define MPURC_DEFS_SVH

// region start register layout
`define MPURC_BASE_LSB 8
`define MPURC_BASE_W 24
`define MPURC_INDEX_LSB 1
`define MPURC_INDEX_W 5
`define MPURC_DSEL_BIT 0

// region attribute register layout
`define MPURC_BOUND_LSB 7
`define MPURC_BOUND_W 25
`define MPURC_MT_LSB 5
`define MPURC_MT_W 2
`define MPURC_ACCESS_RIGHTS_LSB 2
`define MPURC_ACCESS_RIGHTS_W 3
`define MPURC_FETCH_BIT 1
`define MPURC_STORE_BIT 0

// permission codes
`define MPURC_ACCESS_RIGHTS_NONE 3'h0
`define MPURC_ACCESS_RIGHTS_SUP_R 3'h1
`define MPURC_ACCESS_RIGHTS_ALL_R 3'h2
`define MPURC_ACCESS_RIGHTS_SUP_RW 3'h4
`define MPURC_ACCESS_RIGHTS_SUP_RW_USR_R 3'h5
`define MPURC_ACCESS_RIGHTS_ALL_RW 3'h6

// bus word map
`define MPURC_OFF_START 4'h0
`define MPURC_OFF_ATTR 4'h4
`define MPURC_RESP_OKAY 2'h0
`define MPURC_RESP_SLVERR 2'h2

`endif

/* src/mpurc_pkg.sv */
// types for the two ends of the region configuration link: memory type and rights for the device, read states for the host
// assumes the constants header is compiled alongside
package mpurc_pkg;
	typedef enum logic [1:0] {
		MPURC_MT_PERIPH,
		MPURC_MT_NORMAL,
		MPURC_MT_DEVICE,
		MPURC_MT_RESERVED
	} mpurc_mem_type;
	typedef logic [2:0] mpurc_access_rights_type;
	typedef enum logic [1:0] {
		MPURC_RD_IDLE,
		MPURC_RD_WAIT,
		MPURC_RD_RESP
	} mpurc_rd_state_type;
endpackage

/* src/mpurc_ctl_if.sv */
// control-register link between the core side and the region register block
// assumes one clock shared by both ends
`timescale 1ns/100ps
interface mpurc_ctl_if;
	logic wr;
	logic wsel;
	logic [31:0] wdata;
	logic rd;
	logic rsel;
	logic [31:0] rdata;
	logic rvalid;
	modport device(input wr, input wsel, input wdata, input rd, input rsel, output rdata, output rvalid);
	modport core(output wr, output wsel, output wdata, output rd, output rsel, input rdata, input rvalid);
endinterface

/* src/mpurc_field_mask.sv */
// clears the bits of an address field that the configuration leaves unused
// assumes keep bounds are elaboration constants
`timescale 1ns/100ps
module mpurc_field_mask #(
	parameter int WIDTH = 24,
	parameter int KEEP_LO = 0,
	parameter int KEEP_HI = 23
) (
	// field in and out
	input wire logic [WIDTH-1:0] raw_bits,
	output logic [WIDTH-1:0] clean_bits
);
	function automatic logic [WIDTH-1:0] keep_mask();
		logic [WIDTH-1:0] m;
		m = '0;
		for (int i = 0; i < WIDTH; i++) begin
			m[i] = (i >= KEEP_LO) && (i <= KEEP_HI);
		end
		return m;
	endfunction

	assign clean_bits = raw_bits & keep_mask();
endmodule

/* src/mpurc_host.sv */
// core-side end: turns AXI4-Lite word accesses into control-register writes and reads
// assumes the device answers a link read with rvalid exactly one cycle later
`timescale 1ns/100ps
`include "mpurc_defs.svh"
module mpurc_host #(
	parameter int ADDR_W = 4
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// write address channel
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// write data channel
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// write response channel
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// read address channel
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// read data channel
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// control-register link
	mpurc_ctl_if.core ctl
);
	logic aw_held;
	logic w_held;
	logic [ADDR_W-1:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic aw_hit_start;
	logic aw_hit_attr;
	logic ar_hit_start;
	logic ar_hit_attr;
	logic issue_wr;
	mpurc_pkg::mpurc_rd_state_type rd_state;

	assign aw_hit_start = awaddr_reg == ADDR_W'(`MPURC_OFF_START);
	assign aw_hit_attr = awaddr_reg == ADDR_W'(`MPURC_OFF_ATTR);
	assign ar_hit_start = s_axi_araddr == ADDR_W'(`MPURC_OFF_START);
	assign ar_hit_attr = s_axi_araddr == ADDR_W'(`MPURC_OFF_ATTR);
	assign issue_wr = aw_held && w_held && !s_axi_bvalid;

	// address and data are taken in either order, one write at a time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			awaddr_reg <= '0;
			s_axi_awready <= 1'b0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held <= 1'b1;
			awaddr_reg <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end else if (issue_wr) begin
			aw_held <= 1'b0;
		end else if (!aw_held && !s_axi_bvalid) begin
			s_axi_awready <= 1'b1;
		end
	end

	// registers are whole words, so byte strobes are not honoured
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held <= 1'b0;
			wdata_reg <= '0;
			s_axi_wready <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held <= 1'b1;
			wdata_reg <= s_axi_wdata;
			s_axi_wready <= 1'b0;
		end else if (issue_wr) begin
			w_held <= 1'b0;
		end else if (!w_held && !s_axi_bvalid) begin
			s_axi_wready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctl.wr <= 1'b0;
			ctl.wsel <= 1'b0;
			ctl.wdata <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `MPURC_RESP_OKAY;
		end else if (issue_wr) begin
			ctl.wr <= aw_hit_start || aw_hit_attr;
			ctl.wsel <= aw_hit_attr;
			ctl.wdata <= wdata_reg;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (aw_hit_start || aw_hit_attr) ? `MPURC_RESP_OKAY : `MPURC_RESP_SLVERR;
		end else begin
			ctl.wr <= 1'b0;
			if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_state <= mpurc_pkg::MPURC_RD_IDLE;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= `MPURC_RESP_OKAY;
			ctl.rd <= 1'b0;
			ctl.rsel <= 1'b0;
		end else begin
			ctl.rd <= 1'b0;
			unique case (rd_state)
				mpurc_pkg::MPURC_RD_IDLE: begin
					if (s_axi_arvalid && s_axi_arready) begin
						s_axi_arready <= 1'b0;
						if (ar_hit_start || ar_hit_attr) begin
							ctl.rd <= 1'b1;
							ctl.rsel <= ar_hit_attr;
							rd_state <= mpurc_pkg::MPURC_RD_WAIT;
						end else begin
							s_axi_rvalid <= 1'b1;
							s_axi_rdata <= '0;
							s_axi_rresp <= `MPURC_RESP_SLVERR;
							rd_state <= mpurc_pkg::MPURC_RD_RESP;
						end
					end else begin
						s_axi_arready <= 1'b1;
					end
				end
				mpurc_pkg::MPURC_RD_WAIT: begin
					if (ctl.rvalid) begin
						s_axi_rvalid <= 1'b1;
						s_axi_rdata <= ctl.rdata;
						s_axi_rresp <= `MPURC_RESP_OKAY;
						rd_state <= mpurc_pkg::MPURC_RD_RESP;
					end
				end
				mpurc_pkg::MPURC_RD_RESP: begin
					if (s_axi_rready) begin
						s_axi_rvalid <= 1'b0;
						rd_state <= mpurc_pkg::MPURC_RD_IDLE;
					end
				end
			endcase
		end
	end
endmodule

/* testbench/mpurc_link_assertions.sv */
// concurrent checks on the control-register link between host and device ends
// assumes one clock, synchronous active-low reset, parameters matching the device
`timescale 1ns/100ps
module mpurc_link_assertions #(
	parameter int REGION_BITS = 5,
	parameter int MIN_REGION_LOG2 = 8,
	parameter int ADDR_BITS = 32
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// core to device
	input wire logic wr,
	input wire logic wsel,
	input wire logic [31:0] wdata,
	input wire logic rd,
	input wire logic rsel,
	// device to core
	input wire logic [31:0] rdata,
	input wire logic rvalid
);
	localparam logic [32:0] LOW_DROP = (33'h1 << MIN_REGION_LOG2) - 33'h1;
	localparam logic [32:0] HIGH_DROP = ~((33'h1 << ADDR_BITS) - 33'h1);
	localparam logic [4:0] IDX_KEEP = 5'((32'h1 << REGION_BITS) - 32'h1);
	logic written_reg;
	logic known_reg;
	logic [2:0] access_rights_reg;

	// any write ends the all-zero state left by reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			written_reg <= 1'b0;
		end else if (wr) begin
			written_reg <= 1'b1;
		end
	end

	// a fetch reloads rights from the table, so the shadow is lost
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			known_reg <= 1'b1;
			access_rights_reg <= 3'h0;
		end else if (wr && wsel) begin
			known_reg <= !wdata[1];
			access_rights_reg <= wdata[4:2];
		end
	end

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_read_answer: assert property (rd |=> rvalid)
		else $error("link read not answered one cycle later");
	a_answer_cause: assert property (rvalid |-> $past(rd))
		else $error("link answer without a read");
	a_flags_zero: assert property ((rvalid && $past(rsel)) |-> rdata[1:0] == 2'b00)
		else $error("operation flags read back nonzero");
	a_start_hole: assert property ((rvalid && !$past(rsel)) |-> rdata[7:6] == 2'b00)
		else $error("start register gap bits nonzero");
	a_index_unused: assert property ((rvalid && !$past(rsel)) |-> (rdata[5:1] & ~IDX_KEEP) == '0)
		else $error("unused region number bits nonzero");
	a_base_low_zero: assert property ((rvalid && !$past(rsel)) |-> (rdata[31:8] & LOW_DROP[31:8]) == '0)
		else $error("start bits below minimum size nonzero");
	a_base_high_zero: assert property ((rvalid && !$past(rsel)) |-> (rdata[31:8] & HIGH_DROP[31:8]) == '0)
		else $error("start bits above address space nonzero");
	a_access_rights_echo: assert property ((rvalid && $past(rsel) && $past(known_reg)) |-> rdata[4:2] == $past(access_rights_reg))
		else $error("access rights not returned as written");
	a_reset_clear: assert property ((rvalid && !$past(written_reg)) |-> rdata == '0)
		else $error("register not clear after reset");

	c_fetch: cover property (wr && wsel && wdata[1]);
	c_store_data: cover property (wr && wsel && wdata[0] && !wdata[1]);
	c_attr_read: cover property (rvalid && $past(rsel));
endmodule

/* testbench/mpurc_tb.sv */
// self-checking bench: AXI4-Lite master into the host end, device end on the link
// assumes the interface, both ends and the link checker are compiled first
`timescale 1ns/100ps
`include "mpurc_defs.svh"
module tb;
	// small build: 16 regions, 1 KB minimum, 30-bit address space
	localparam int RB = 4;
	localparam int MINL = 10;
	localparam int AB = 30;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [3:0] awaddr = 4'h0, araddr = 4'h0;
	logic [31:0] wdata = 32'h0000_0000;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic lk_data = 1'b0;
	logic [RB-1:0] lk_index = '0;
	logic [23:0] lk_base;
	logic [24:0] lk_limit;
	logic lk_c, lk_b, lk_sr, lk_sw, lk_ur, lk_uw, lk_sx, lk_ux;
	int fail_count = 0;
	int n_compared = 0;
	logic [3:0] access_rights_dec [0:6] = '{4'h0, 4'h8, 4'hA, 4'h0, 4'hC, 4'hE, 4'hF};
	logic [2:0] access_rights_list [0:5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};

	always #20 aclk = ~aclk;

	mpurc_ctl_if i_mpurc_ctl_if();
	mpurc_host #(.ADDR_W(4)) i_mpurc_host (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.ctl(i_mpurc_ctl_if));
	mpurc_device #(.REGION_BITS(RB), .MIN_REGION_LOG2(MINL), .ADDR_BITS(AB)) i_mpurc_device (
		.aclk(aclk), .aresetn(aresetn), .ctl(i_mpurc_ctl_if),
		.lookup_data(lk_data), .lookup_index(lk_index), .lookup_base(lk_base), .lookup_limit(lk_limit),
		.lookup_cacheable(lk_c), .lookup_bufferable(lk_b), .lookup_sup_read(lk_sr),
		.lookup_sup_write(lk_sw), .lookup_user_read(lk_ur), .lookup_user_write(lk_uw),
		.lookup_sup_exec(lk_sx), .lookup_user_exec(lk_ux));
	mpurc_link_assertions #(.REGION_BITS(RB), .MIN_REGION_LOG2(MINL), .ADDR_BITS(AB)) u_link_chk (
		.aclk(aclk), .aresetn(aresetn), .wr(i_mpurc_ctl_if.wr), .wsel(i_mpurc_ctl_if.wsel),
		.wdata(i_mpurc_ctl_if.wdata), .rd(i_mpurc_ctl_if.rd), .rsel(i_mpurc_ctl_if.rsel),
		.rdata(i_mpurc_ctl_if.rdata), .rvalid(i_mpurc_ctl_if.rvalid));

	// build variants listen to the same link: bound field, and no protection hardware
	mpurc_ctl_if i_mpurc_ctl_if_var[2]();
	for (genvar g = 0; g < 2; g++) begin : g_mirror
		assign i_mpurc_ctl_if_var[g].wr = i_mpurc_ctl_if.wr;
		assign i_mpurc_ctl_if_var[g].wsel = i_mpurc_ctl_if.wsel;
		assign i_mpurc_ctl_if_var[g].wdata = i_mpurc_ctl_if.wdata;
		assign i_mpurc_ctl_if_var[g].rd = i_mpurc_ctl_if.rd;
		assign i_mpurc_ctl_if_var[g].rsel = i_mpurc_ctl_if.rsel;
	end
	mpurc_device #(.USE_LIMIT(1'b1)) i_mpurc_device_lim (.aclk(aclk), .aresetn(aresetn),
		.ctl(i_mpurc_ctl_if_var[0]), .lookup_data(1'b0), .lookup_index(5'h00), .lookup_base(), .lookup_limit(),
		.lookup_cacheable(), .lookup_bufferable(), .lookup_sup_read(), .lookup_sup_write(), .lookup_user_read(),
		.lookup_user_write(), .lookup_sup_exec(), .lookup_user_exec());
	mpurc_device #(.MPU_PRESENT(1'b0)) i_mpurc_device_off (.aclk(aclk), .aresetn(aresetn),
		.ctl(i_mpurc_ctl_if_var[1]), .lookup_data(1'b0), .lookup_index(5'h00), .lookup_base(), .lookup_limit(),
		.lookup_cacheable(), .lookup_bufferable(), .lookup_sup_read(), .lookup_sup_write(), .lookup_user_read(),
		.lookup_user_write(), .lookup_sup_exec(), .lookup_user_exec());

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_done, w_done, b_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		b_done = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!b_done) begin
			@(posedge aclk);
			if (!aw_done && awready) begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_done && wready) begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
			if (bvalid) begin
				b_done = 1'b1;
				bready <= 1'b0;
				chk("bresp", 32'(er), 32'(bresp));
			end
		end
	endtask

	// read and judge data and response in one go
	task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] er);
		logic ar_done, r_done;
		ar_done = 1'b0;
		r_done = 1'b0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!r_done) begin
			@(posedge aclk);
			if (!ar_done && arready) begin
				ar_done = 1'b1;
				arvalid <= 1'b0;
			end
			if (rvalid) begin
				r_done = 1'b1;
				rready <= 1'b0;
				chk("rdata", exp, rdata);
				chk("rresp", 32'(er), 32'(rresp));
			end
		end
	endtask

	// lookup outputs follow their inputs one cycle later
	task automatic lk_chk(input logic d, input logic [RB-1:0] idx, input logic [24:0] lim, input logic [31:0] exp);
		@(posedge aclk);
		lk_data <= d;
		lk_index <= idx;
		repeat (2) @(posedge aclk);
		#1;
		chk("lookup", exp, {lk_base, lk_c, lk_b, lk_sr, lk_sw, lk_ur, lk_uw, lk_sx, lk_ux});
		chk("limit", 32'(lim), 32'(lk_limit));
	endtask

	task automatic t_reset;
		rd_chk(`MPURC_OFF_START, 32'h0000_0000, `MPURC_RESP_OKAY);
		rd_chk(`MPURC_OFF_ATTR, 32'h0000_0000, `MPURC_RESP_OKAY);
		rd_chk(4'h8, 32'h0000_0000, `MPURC_RESP_SLVERR);
		axi_wr(4'hC, 32'hFFFF_FFFF, `MPURC_RESP_SLVERR);
		$display("test reset done");
	endtask

	// all-ones writes, flag bits left clear: unused start, number and size bits must come back clear
	task automatic t_fields;
		axi_wr(`MPURC_OFF_START, 32'hFFFF_FFFF, `MPURC_RESP_OKAY);
		rd_chk(`MPURC_OFF_START, 32'h3FFF_FC1F, `MPURC_RESP_OKAY);
		chk("absent start", 32'h0000_0000, i_mpurc_ctl_if_var[1].rdata);
		axi_wr(`MPURC_OFF_ATTR, 32'hFFFF_FFFC, `MPURC_RESP_OKAY);
		rd_chk(`MPURC_OFF_ATTR, 32'h1FFF_FE7C, `MPURC_RESP_OKAY);
		chk("bound attr", 32'hFFFF_FFFC, i_mpurc_ctl_if_var[0].rdata);
		chk("absent attr", 32'h0000_0000, i_mpurc_ctl_if_var[1].rdata);
		$display("test fields done");
	endtask

	task automatic t_slots;
		logic [31:0] sw, aw;
		logic [1:0] m;
		for (int k = 0; k < 6; k++) begin
			m = 2'(k % 4);
			axi_wr(`MPURC_OFF_START, 32'((k + 1) << 16) | 32'(k << 1) | 32'h0000_0001, `MPURC_RESP_OKAY);
			axi_wr(`MPURC_OFF_ATTR, 32'h1FFF_F801 | 32'(m) << 5 | 32'(access_rights_list[k]) << 2, `MPURC_RESP_OKAY);
		end
		axi_wr(`MPURC_OFF_START, 32'h0007_0006, `MPURC_RESP_OKAY);
		axi_wr(`MPURC_OFF_ATTR, 32'h1FFF_F809, `MPURC_RESP_OKAY);
		axi_wr(`MPURC_OFF_START, 32'h0000_0000, `MPURC_RESP_OKAY);
		axi_wr(`MPURC_OFF_ATTR, 32'h0000_0000, `MPURC_RESP_OKAY);
		for (int k = 0; k < 6; k++) begin
			m = 2'(k % 4);
			sw = 32'((k + 1) << 16) | 32'(k << 1) | 32'h0000_0001;
			aw = 32'h1FFF_F800 | 32'(m) << 5 | 32'(access_rights_list[k]) << 2;
			axi_wr(`MPURC_OFF_START, 32'(k << 1) | 32'h0000_0001, `MPURC_RESP_OKAY);
			axi_wr(`MPURC_OFF_ATTR, 32'h0000_0002, `MPURC_RESP_OKAY);
			rd_chk(`MPURC_OFF_START, sw, `MPURC_RESP_OKAY);
			rd_chk(`MPURC_OFF_ATTR, aw, `MPURC_RESP_OKAY);
			// size code 0x3FFFF0 in a 30-bit space is 4 KB, sixteen units past the base
			lk_chk(1'b1, RB'(k), 25'(((k + 1) << 8) + 16), {24'((k + 1) << 8), m == 2'h1,
				m == 2'h1 || m == 2'h2, access_rights_dec[access_rights_list[k]], 2'b00});
		end
		axi_wr(`MPURC_OFF_START, 32'h0000_0006, `MPURC_RESP_OKAY);
		axi_wr(`MPURC_OFF_ATTR, 32'h0000_0002, `MPURC_RESP_OKAY);
		rd_chk(`MPURC_OFF_START, 32'h0007_0006, `MPURC_RESP_OKAY);
		rd_chk(`MPURC_OFF_ATTR, 32'h1FFF_F808, `MPURC_RESP_OKAY);
		lk_chk(1'b0, RB'(3), 25'h0_0710, {24'h00_0700, 8'h03});
		$display("test slots done");
	endtask

	task automatic test_done;
		$display("comparisons %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset;
		t_fields;
		t_slots;
		test_done;
	end

	// whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge aclk);
		fail_count++;
		$display("watchdog expired");
		test_done;
	end
endmodule
